// ---- rtl/prs_pkg.sv ----
package prs_pkg;

  // timing base; the reference clock ref_clk is 40 MHz
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RST_HOLD_MS = 100;
  localparam int unsigned WARN_MASK_MS = 60;
  localparam int unsigned RST_HOLD_CYC = CLK_HZ / 1000 * RST_HOLD_MS;
  localparam int unsigned WARN_MASK_CYC = CLK_HZ / 1000 * WARN_MASK_MS;
  localparam int unsigned CNT_W = 23;

  localparam int unsigned GPIO_W = 32;
  localparam int unsigned INIT_PIN = 26;
  localparam int unsigned MIR_OUT_W = 8;

  typedef enum logic [1:0] {
    PRS_NORMAL,
    PRS_STANDBY
  } prs_pwr_e;

  typedef enum {
    PRS_OFF,
    PRS_HOLD,
    PRS_BOOT,
    PRS_DCG_CFG,
    PRS_PLL_EN,
    PRS_RATE_SET,
    PRS_DIV_REL,
    PRS_MEMTEST,
    PRS_DONE,
    PRS_PARK,
    PRS_SLEEP
  } prs_state_e;

  // processor-side bring-up steps, park done and sleep/wake requests
  typedef struct packed {
    logic boot_done;
    logic dcg_cfg_done;
    logic rate_set_done;
    logic memtest_done;
    logic park_done;
    logic sleep_req;
    logic wake_req;
  } prs_fw_s;

  // reset, clock, bring-up, park and power-mode controls driven to the rest of the chip
  typedef struct packed {
    logic master_pll_rst;
    logic cpu_rst;
    logic cpu_clk_full;
    logic mirror_clock_pll_pd;
    logic div_rst;
    logic mirror_clk_en;
    logic ddr_cfg_en;
    logic memtest_start;
    logic park_req;
    prs_pwr_e pwr_mode;
  } prs_ctl_s;

  localparam int unsigned STATE_PAD = 0;

endpackage : prs_pkg

// ---- rtl/prs_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
#(
  // reset hold and warning mask lengths in clock cycles
  parameter int unsigned HOLD_CYC = RST_HOLD_CYC,
  parameter int unsigned MASK_CYC = WARN_MASK_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // power monitor
  input wire logic power_on_sense,
  input wire logic power_loss_warning,
  // processor bring-up
  input wire prs_pkg::prs_fw_s fw,
  input wire logic mirror_clock_pll_lock,
  // chip controls
  output var prs_pkg::prs_ctl_s ctl,
  // pins
  output logic [prs_pkg::GPIO_W-1:0] gpio_out,
  output logic [prs_pkg::GPIO_W-1:0] gpio_oe,
  output logic [prs_pkg::MIR_OUT_W-1:0] mirror_out,
  output logic mirror_reset_ctrl_output_enable,
  output logic mirror_reset_ctrl_output_enable_oe
);
  import prs_pkg::*;

  typedef struct packed {
    logic [1:0] sense_sync;
    logic [1:0] warn_sync;
    logic sense_prev;
    logic warn_prev;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] mask_cnt;
    prs_state_e st;
    prs_ctl_s ctl;
    logic init_done;
  } prs_state_s;

  prs_state_s s_r, s_nxt;

  wire logic sense = s_r.sense_sync[1];
  wire logic warn_ok = s_r.warn_sync[1];
  wire logic sense_rise = sense && !s_r.sense_prev;
  wire logic masked = s_r.mask_cnt != '0;
  wire logic warn_fall = !warn_ok && s_r.warn_prev && !masked;

  function automatic prs_ctl_s reset_ctl(input logic pll_rst);
    prs_ctl_s c;
    c.master_pll_rst = pll_rst;
    c.cpu_rst = 1'b1;
    c.cpu_clk_full = 1'b1;
    c.mirror_clock_pll_pd = 1'b1;
    c.div_rst = 1'b1;
    c.mirror_clk_en = 1'b0;
    c.ddr_cfg_en = 1'b0;
    c.memtest_start = 1'b0;
    c.park_req = 1'b0;
    c.pwr_mode = PRS_NORMAL;
    return c;
  endfunction : reset_ctl

  always_comb begin
    s_nxt = s_r;
    // first flop feeds only the second
    s_nxt.sense_sync = {s_r.sense_sync[0], power_on_sense};
    s_nxt.warn_sync = {s_r.warn_sync[0], power_loss_warning};
    s_nxt.sense_prev = sense;
    s_nxt.warn_prev = warn_ok;
    if (masked) begin
      s_nxt.mask_cnt = s_r.mask_cnt - 1'b1;
    end
    if (!sense) begin
      s_nxt.st = PRS_OFF;
      s_nxt.ctl = reset_ctl(1'b1);
      s_nxt.init_done = 1'b0;
      s_nxt.hold_cnt = '0;
      s_nxt.mask_cnt = '0;
    end else if (sense_rise) begin
      s_nxt.st = PRS_HOLD;
      s_nxt.ctl = reset_ctl(1'b0);
      s_nxt.hold_cnt = CNT_W'(HOLD_CYC - 1);
      s_nxt.mask_cnt = CNT_W'(MASK_CYC);
      s_nxt.init_done = 1'b0;
    end else if (warn_fall && s_r.st != PRS_HOLD) begin
      s_nxt.st = PRS_PARK;
      s_nxt.ctl.park_req = 1'b1;
    end else begin
      case (s_r.st)
        PRS_HOLD: begin
          if (s_r.hold_cnt == '0) begin
            s_nxt.st = PRS_BOOT;
            s_nxt.ctl.cpu_rst = 1'b0;
          end else begin
            s_nxt.hold_cnt = s_r.hold_cnt - 1'b1;
          end
        end
        PRS_BOOT: if (fw.boot_done) begin
          s_nxt.st = PRS_DCG_CFG;
          s_nxt.ctl.ddr_cfg_en = 1'b1;
        end
        PRS_DCG_CFG: if (fw.dcg_cfg_done) begin
          s_nxt.st = PRS_PLL_EN;
          s_nxt.ctl.ddr_cfg_en = 1'b0;
          s_nxt.ctl.mirror_clock_pll_pd = 1'b0;
        end
        PRS_PLL_EN: if (mirror_clock_pll_lock) begin
          s_nxt.st = PRS_RATE_SET;
        end
        PRS_RATE_SET: if (fw.rate_set_done) begin
          s_nxt.st = PRS_DIV_REL;
        end
        PRS_DIV_REL: begin
          s_nxt.st = PRS_MEMTEST;
          s_nxt.ctl.div_rst = 1'b0;
          s_nxt.ctl.mirror_clk_en = 1'b1;
          s_nxt.ctl.memtest_start = 1'b1;
        end
        PRS_MEMTEST: if (fw.memtest_done) begin
          s_nxt.st = PRS_DONE;
          s_nxt.ctl.memtest_start = 1'b0;
          s_nxt.init_done = 1'b1;
        end
        PRS_DONE: if (fw.sleep_req) begin
          s_nxt.st = PRS_SLEEP;
          s_nxt.ctl.pwr_mode = PRS_STANDBY;
        end
        PRS_PARK: if (fw.park_done) begin
          s_nxt.ctl.park_req = 1'b0;
          s_nxt.st = PRS_SLEEP;
          s_nxt.ctl.pwr_mode = PRS_STANDBY;
        end
        PRS_SLEEP: if (fw.wake_req && warn_ok) begin
          s_nxt.st = PRS_DCG_CFG;
          s_nxt.ctl = reset_ctl(1'b0);
          s_nxt.ctl.cpu_rst = 1'b0;
          s_nxt.ctl.ddr_cfg_en = 1'b1;
          s_nxt.init_done = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= PRS_OFF;
      s_r.ctl <= reset_ctl(1'b1);
    end else begin
      s_r <= s_nxt;
    end
  end

  // gpio stays undriven except the init pin once done
  always_comb begin
    gpio_out = '0;
    gpio_oe = '0;
    gpio_out[INIT_PIN] = s_r.init_done;
    gpio_oe[INIT_PIN] = s_r.init_done;
  end

  assign ctl = s_r.ctl;
  assign mirror_out = '0;
  assign mirror_reset_ctrl_output_enable = 1'b0;
  assign mirror_reset_ctrl_output_enable_oe = 1'b0;

  int unsigned hold_len;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || s_r.st != PRS_HOLD) begin
      hold_len <= 0;
    end else begin
      hold_len <= hold_len + 1;
    end
  end

  off_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_r.sense_sync[1] |=> ctl.cpu_rst && ctl.master_pll_rst)
    else $error("reset not held while sense low");
  pll_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sense_rise |=> !ctl.master_pll_rst && ctl.cpu_rst)
    else $error("master pll not released on rise");
  hold_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(ctl.cpu_rst) && $past(s_r.st) == PRS_HOLD
      |-> hold_len == HOLD_CYC)
    else $error("boot reset hold length wrong");
  warn_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sense_rise |=> s_r.mask_cnt == CNT_W'(MASK_CYC))
    else $error("warning mask not loaded");
  park_on_warn_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sense && !sense_rise && warn_fall && s_r.st != PRS_HOLD
      |=> ctl.park_req)
    else $error("park not requested on warning");
  gpio_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_r.init_done |-> gpio_oe == '0)
    else $error("gpio driven before init done");
  pll_down_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctl.mirror_clock_pll_pd |-> ctl.div_rst && !ctl.mirror_clk_en)
    else $error("mirror clocks active with pll down");
  div_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(ctl.div_rst) |-> $past(s_r.st) == PRS_DIV_REL
      && !ctl.mirror_clock_pll_pd)
    else $error("divider released out of order");
  init_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(gpio_out[INIT_PIN]) |-> $past(fw.memtest_done))
    else $error("init done without memory test");

  boot_c: cover property (@(posedge ref_clk) $fell(ctl.cpu_rst));
  done_c: cover property (@(posedge ref_clk) $rose(s_r.init_done));
  park_c: cover property (@(posedge ref_clk) $rose(ctl.park_req));
  wake_c: cover property (@(posedge ref_clk)
    s_r.st == PRS_SLEEP && fw.wake_req && warn_ok);

endmodule : prs_sequencer
`default_nettype wire

// ---- tb/prs_pwr_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module prs_pwr_monitor (
  // clock
  input wire logic ref_clk,
  // supply state from the bench
  input wire logic supplies_ok,
  input wire logic loss_soon,
  // monitor outputs
  output logic power_on_sense,
  output logic power_loss_warning
);
  logic [3:0] settle_r;
  initial begin
    settle_r = 4'h0;
    power_on_sense = 1'b0;
    power_loss_warning = 1'b0;
  end
  // sense held low until the supplies have settled
  always @(posedge ref_clk) begin
    if (!supplies_ok) settle_r <= 4'h0;
    else if (settle_r != 4'hf) settle_r <= settle_r + 4'h1;
    power_on_sense <= supplies_ok && settle_r == 4'hf;
    power_loss_warning <= supplies_ok && !loss_soon;
  end
endmodule : prs_pwr_monitor
`default_nettype wire

// ---- tb/prs_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer_tb_top;
  import prs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supplies_ok = 1'b0;
  logic loss_soon = 1'b0;
  logic sense;
  logic warn;
  prs_fw_s fw = '0;
  logic lock = 1'b0;
  prs_ctl_s ctl;
  prs_ctl_s rst_ctl;
  logic [GPIO_W-1:0] gpio_out;
  logic [GPIO_W-1:0] gpio_oe;
  logic [MIR_OUT_W-1:0] mirror_out;
  logic mr_en;
  logic mr_oe;
  int err_count = 0;
  int n_tests = 0;
  // shortened hold and mask so boot is reached within the run
  localparam int TB_HOLD_CYC = 400;
  localparam int TB_MASK_CYC = 600;
  // 500 us warning lead at 40 MHz
  localparam int WARN_LEAD_CYC = 20000;
  localparam logic [GPIO_W-1:0] INIT_MASK = GPIO_W'(1) << INIT_PIN;
  always #12.5 ref_clk = ~ref_clk;
  prs_pwr_monitor prs_pwr_monitor_inst (.ref_clk(ref_clk),
    .supplies_ok(supplies_ok), .loss_soon(loss_soon),
    .power_on_sense(sense), .power_loss_warning(warn));
  prs_sequencer #(.HOLD_CYC(TB_HOLD_CYC), .MASK_CYC(TB_MASK_CYC))
    prs_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .power_on_sense(sense), .power_loss_warning(warn), .fw(fw),
    .mirror_clock_pll_lock(lock), .ctl(ctl), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .mirror_out(mirror_out),
    .mirror_reset_ctrl_output_enable(mr_en),
    .mirror_reset_ctrl_output_enable_oe(mr_oe));
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic idle_checks();
    chk("ctl", 32'(rst_ctl), 32'(ctl));
    chk("gpio_oe", '0, gpio_oe);
    chk("gpio_out", '0, gpio_out);
    chk("mirror_out", '0, 32'(mirror_out));
    chk("drc_enable", '0, 32'({mr_en, mr_oe}));
  endtask : idle_checks
  // pll release, exact core hold, boot defaults, masked warning
  task automatic wait_boot();
    int i;
    for (i = 0; i < 8 && ctl.master_pll_rst !== 1'b0; i++) begin
      chk("core held", 1, 32'(ctl.cpu_rst));
      @(posedge ref_clk);
    end
    chk("pll released", 0, 32'(ctl.master_pll_rst));
    if (ctl.master_pll_rst !== 1'b0) stop_test();
    for (i = 0; i < TB_HOLD_CYC + 8 && ctl.cpu_rst === 1'b1; i++)
      @(posedge ref_clk);
    chk("hold cycles", TB_HOLD_CYC, i);
    chk("core hold", 0, 32'(ctl.cpu_rst));
    if (ctl.cpu_rst !== 1'b0) stop_test();
    chk("cpu full", 1, 32'(ctl.cpu_clk_full));
    chk("mirror pll down", 1, 32'(ctl.mirror_clock_pll_pd));
    chk("div reset", 1, 32'(ctl.div_rst));
    chk("mirror clk", 0, 32'(ctl.mirror_clk_en));
    chk("mode", 32'(PRS_NORMAL), 32'(ctl.pwr_mode));
    chk("init pin", 0, gpio_oe);
    chk("boot mirror", 0, 32'(mirror_out));
    // warning falls after boot but inside the mask window
    loss_soon <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk("park masked", 0, 32'(ctl.park_req));
    chk("div kept", 1, 32'(ctl.div_rst));
    loss_soon <= 1'b0;
  endtask : wait_boot
  // supplies up, then the monitor raises sense
  task automatic power_up();
    int i;
    @(posedge ref_clk);
    supplies_ok <= 1'b1;
    for (i = 0; i < 40 && sense !== 1'b1; i++) @(posedge ref_clk);
    chk("sense up", 1, 32'(sense));
    if (sense !== 1'b1) stop_test();
    wait_boot();
  endtask : power_up
  // processor steps, each answered one edge after it is seen
  task automatic bring_up();
    fw.boot_done <= 1'b1;
    @(posedge ref_clk);
    fw.boot_done <= 1'b0;
    @(posedge ref_clk);
    chk("ddr cfg", 1, 32'(ctl.ddr_cfg_en));
    chk("pll still down", 1, 32'(ctl.mirror_clock_pll_pd));
    fw.dcg_cfg_done <= 1'b1;
    @(posedge ref_clk);
    fw.dcg_cfg_done <= 1'b0;
    @(posedge ref_clk);
    chk("pll up", 0, 32'(ctl.mirror_clock_pll_pd));
    chk("ddr cfg off", 0, 32'(ctl.ddr_cfg_en));
    chk("div on lock", 1, 32'(ctl.div_rst));
    lock <= 1'b1;
    @(posedge ref_clk);
    fw.rate_set_done <= 1'b1;
    @(posedge ref_clk);
    fw.rate_set_done <= 1'b0;
    chk("div at rate", 1, 32'(ctl.div_rst));
    repeat (2) @(posedge ref_clk);
    chk("div released", 0, 32'(ctl.div_rst));
    chk("mirror clk on", 1, 32'(ctl.mirror_clk_en));
    chk("memtest run", 1, 32'(ctl.memtest_start));
    chk("init early", 0, gpio_oe);
    fw.memtest_done <= 1'b1;
    @(posedge ref_clk);
    fw.memtest_done <= 1'b0;
    @(posedge ref_clk);
    chk("init out", INIT_MASK, gpio_out);
    chk("init oe", INIT_MASK, gpio_oe);
    chk("memtest end", 0, 32'(ctl.memtest_start));
  endtask : bring_up
  // standby on request, wake restores normal and restarts clocks
  task automatic sleep_wake();
    fw.sleep_req <= 1'b1;
    @(posedge ref_clk);
    fw.sleep_req <= 1'b0;
    @(posedge ref_clk);
    chk("mode sleep", 32'(PRS_STANDBY), 32'(ctl.pwr_mode));
    fw.wake_req <= 1'b1;
    @(posedge ref_clk);
    fw.wake_req <= 1'b0;
    lock <= 1'b0;
    @(posedge ref_clk);
    chk("mode wake", 32'(PRS_NORMAL), 32'(ctl.pwr_mode));
    chk("wake ddr", 1, 32'(ctl.ddr_cfg_en));
    chk("wake pll", 1, 32'(ctl.mirror_clock_pll_pd));
    chk("wake init", 0, gpio_oe);
    chk("wake cpu", 0, 32'(ctl.cpu_rst));
    chk("wake master", 0, 32'(ctl.master_pll_rst));
    bring_up();
  endtask : sleep_wake
  // warning after the mask parks the array; wake refused while low
  task automatic park_drop();
    int i;
    repeat (TB_MASK_CYC) @(posedge ref_clk);
    loss_soon <= 1'b1;
    for (i = 0; i < 8 && ctl.park_req !== 1'b1; i++) @(posedge ref_clk);
    chk("park req", 1, 32'(ctl.park_req));
    if (ctl.park_req !== 1'b1) stop_test();
    fw.park_done <= 1'b1;
    @(posedge ref_clk);
    fw.park_done <= 1'b0;
    fw.wake_req <= 1'b1;
    @(posedge ref_clk);
    fw.wake_req <= 1'b0;
    chk("park end", 0, 32'(ctl.park_req));
    chk("park mode", 32'(PRS_STANDBY), 32'(ctl.pwr_mode));
    @(posedge ref_clk);
    chk("wake refused", 32'(PRS_STANDBY), 32'(ctl.pwr_mode));
    repeat (WARN_LEAD_CYC) @(posedge ref_clk);
    power_drop();
  endtask : park_drop
  // sense drop brings every control back to its reset value
  task automatic power_drop();
    int i;
    @(posedge ref_clk);
    supplies_ok <= 1'b0;
    loss_soon <= 1'b0;
    lock <= 1'b0;
    for (i = 0; i < 8 && ctl.master_pll_rst !== 1'b1; i++) @(posedge ref_clk);
    chk("pll reset", 1, 32'(ctl.master_pll_rst));
    if (ctl.master_pll_rst !== 1'b1) stop_test();
    @(posedge ref_clk);
    idle_checks();
  endtask : power_drop
  // mid-run system reset returns to defaults
  task automatic sys_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("reset ctl", 32'(rst_ctl), 32'(ctl));
    chk("reset gpio", '0, gpio_oe);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_boot();
  endtask : sys_reset
  initial begin
    rst_ctl = '0;
    rst_ctl.master_pll_rst = 1'b1;
    rst_ctl.cpu_rst = 1'b1;
    rst_ctl.cpu_clk_full = 1'b1;
    rst_ctl.mirror_clock_pll_pd = 1'b1;
    rst_ctl.div_rst = 1'b1;
    rst_ctl.pwr_mode = PRS_NORMAL;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (50) @(posedge ref_clk);
    #1 idle_checks();
    power_up();
    bring_up();
    sleep_wake();
    park_drop();
    power_up();
    bring_up();
    sys_reset();
    power_drop();
    stop_test();
  end
endmodule : prs_sequencer_tb_top
`default_nettype wire
